// ===== hdl/flash_cmd_host.sv
`timescale 1ns/1ps
// Host-side command sequencer and status poller for a parallel flash
module flash_cmd_host
    import flash_host_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Software register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Flash pins
    output logic [ADDR_W-1:0] fl_addr_o,
    output logic [DATA_W-1:0] fl_dq_o,
    output logic fl_dq_oe_o,
    input wire logic [DATA_W-1:0] fl_dq_i,
    output logic fl_ce_n_o,
    output logic fl_oe_n_o,
    output logic fl_we_n_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ISSUE = 3'b001,
        ST_WAIT = 3'b011,
        ST_POLL = 3'b010,
        ST_POLL_WAIT = 3'b110,
        ST_DECIDE = 3'b111
    } seq_state_t;

    seq_state_t state;
    logic [3:0] op;
    logic [ADDR_W-1:0] target_addr;
    logic [DATA_W-1:0] target_data;
    logic [2:0] step;
    logic [2:0] last_step;
    logic [1:0] poll_phase;
    logic [DATA_W-1:0] first_read;
    logic [DATA_W-1:0] read_value;
    logic busy;
    logic done;
    logic fail;
    logic reject;
    logic window_before;
    logic cy_start;
    logic cy_write;
    logic [ADDR_W-1:0] cy_addr;
    logic [DATA_W-1:0] cy_data;
    logic cy_done;
    logic [DATA_W-1:0] cy_rdata;
    logic ctrl_wr;

    // Number of the last write cycle in each command sequence
    function automatic logic [2:0] seq_len(input logic [3:0] code);
        case (code)
            OP_PROGRAM: seq_len = 3'd3;
            OP_CHIP_ERASE: seq_len = 3'd5;
            OP_SECTOR_ERASE: seq_len = 3'd5;
            OP_IDENT: seq_len = 3'd2;
            default: seq_len = 3'd0;
        endcase
    endfunction

    // Address and data of write cycle n of the running sequence
    function automatic logic [ADDR_W+DATA_W-1:0] seq_cycle(
        input logic [3:0] code, input logic [2:0] n,
        input logic [ADDR_W-1:0] ta, input logic [DATA_W-1:0] td);
        logic [7:0] third;
        third = CMD_IDENT;
        case (code)
            OP_PROGRAM: third = CMD_PROGRAM;
            OP_CHIP_ERASE: third = CMD_ERASE_SETUP;
            OP_SECTOR_ERASE: third = CMD_ERASE_SETUP;
            default: third = CMD_IDENT;
        endcase
        case (code)
            OP_SUSPEND: seq_cycle = {ta, CMD_SUSPEND};
            OP_RESUME: seq_cycle = {ta, CMD_RESUME};
            OP_EXTRA_SECTOR: seq_cycle = {ta, CMD_SECTOR_ERASE};
            OP_RAW_WRITE: seq_cycle = {ta, td};
            default:
            begin
                case (n)
                    3'd0: seq_cycle = {UNLOCK_ADDR_A, UNLOCK_DATA_A};
                    3'd1: seq_cycle = {UNLOCK_ADDR_B, UNLOCK_DATA_B};
                    3'd2: seq_cycle = {UNLOCK_ADDR_A, third};
                    3'd3: seq_cycle = (code == OP_PROGRAM) ? {ta, td}
                                     : {UNLOCK_ADDR_A, UNLOCK_DATA_A};
                    3'd4: seq_cycle = {UNLOCK_ADDR_B, UNLOCK_DATA_B};
                    default: seq_cycle = (code == OP_CHIP_ERASE)
                                       ? {UNLOCK_ADDR_A, CMD_CHIP_ERASE}
                                       : {ta, CMD_SECTOR_ERASE};
                endcase
            end
        endcase
    endfunction

    // One flash bus cycle at a time
    flash_bus_cycle u_cycle (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .start_i(cy_start),
        .write_i(cy_write),
        .addr_i(cy_addr),
        .wdata_i(cy_data),
        .done_o(cy_done),
        .rdata_o(cy_rdata),
        .fl_addr_o(fl_addr_o),
        .fl_dq_o(fl_dq_o),
        .fl_dq_oe_o(fl_dq_oe_o),
        .fl_dq_i(fl_dq_i),
        .fl_ce_n_o(fl_ce_n_o),
        .fl_oe_n_o(fl_oe_n_o),
        .fl_we_n_o(fl_we_n_o)
    );

    assign ctrl_wr = reg_wr_i && (reg_addr_i == REG_CTRL) && !busy;

    // Operation parameters written by software
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            target_addr <= '0;
            target_data <= '0;
        end
        else if (reg_wr_i && !busy)
        begin
            if (reg_addr_i == REG_ADDR)
                target_addr <= reg_wdata_i[ADDR_W-1:0];
            if (reg_addr_i == REG_DATA)
                target_data <= reg_wdata_i[DATA_W-1:0];
        end
    end

    // Sequencer: issue write cycles, then poll status until done or failed
    always_ff @(posedge clk_i)
    begin
        cy_start <= 1'b0;
        if (!resetn_i)
        begin
            state <= ST_IDLE;
            op <= OP_READ;
            step <= 3'd0;
            last_step <= 3'd0;
            poll_phase <= 2'd0;
            first_read <= '0;
            read_value <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            reject <= 1'b0;
            window_before <= 1'b0;
            cy_write <= 1'b0;
            cy_addr <= '0;
            cy_data <= '0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (ctrl_wr)
                    begin
                        op <= reg_wdata_i[3:0];
                        last_step <= seq_len(reg_wdata_i[3:0]);
                        step <= 3'd0;
                        busy <= 1'b1;
                        done <= 1'b0;
                        fail <= 1'b0;
                        reject <= 1'b0;
                        poll_phase <= 2'd0;
                        if (reg_wdata_i[3:0] == OP_READ || reg_wdata_i[3:0] == OP_EXTRA_SECTOR)
                        begin
                            // Plain read, or erase-window check ahead of extra sector
                            cy_write <= 1'b0;
                            cy_addr <= target_addr;
                            cy_start <= 1'b1;
                            state <= (reg_wdata_i[3:0] == OP_READ) ? ST_WAIT : ST_POLL_WAIT;
                        end
                        else
                            state <= ST_ISSUE;
                    end
                end
                ST_ISSUE:
                begin
                    cy_write <= 1'b1;
                    {cy_addr, cy_data} <= seq_cycle(op, step, target_addr, target_data);
                    cy_start <= 1'b1;
                    state <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (cy_done)
                    begin
                        if (!cy_write)
                        begin
                            read_value <= cy_rdata;
                            busy <= 1'b0;
                            done <= 1'b1;
                            state <= ST_IDLE;
                        end
                        else if (step != last_step)
                        begin
                            step <= step + 3'd1;
                            state <= ST_ISSUE;
                        end
                        else if (op == OP_PROGRAM || op == OP_CHIP_ERASE
                                 || op == OP_SECTOR_ERASE || op == OP_RESUME)
                        begin
                            // Completion only visible by polling the data bus
                            poll_phase <= 2'd0;
                            state <= ST_POLL;
                        end
                        else if (op == OP_EXTRA_SECTOR)
                        begin
                            poll_phase <= 2'd2;
                            state <= ST_POLL;
                        end
                        else
                        begin
                            // Identification entered, suspend issued or raw write done
                            busy <= 1'b0;
                            done <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_POLL:
                begin
                    // Status polls go to the target so sector flags are meaningful
                    cy_write <= 1'b0;
                    cy_addr <= target_addr;
                    cy_start <= 1'b1;
                    state <= ST_POLL_WAIT;
                end
                ST_POLL_WAIT:
                begin
                    if (cy_done)
                    begin
                        first_read <= cy_rdata;
                        if (op == OP_EXTRA_SECTOR && poll_phase == 2'd0)
                        begin
                            window_before <= cy_rdata[WINDOW_BIT];
                            state <= ST_ISSUE;
                        end
                        else if (op == OP_EXTRA_SECTOR)
                        begin
                            // Window closed before or after the command: it may have been dropped
                            reject <= window_before || cy_rdata[WINDOW_BIT];
                            read_value <= cy_rdata;
                            busy <= 1'b0;
                            done <= 1'b1;
                            state <= ST_IDLE;
                        end
                        else
                            state <= ST_DECIDE;
                    end
                end
                ST_DECIDE:
                begin
                    // Needs a second read to compare the toggle flag
                    if (poll_phase == 2'd0)
                    begin
                        poll_phase <= 2'd1;
                        state <= ST_POLL;
                    end
                    else if (first_read[TOGGLE_BIT] == read_value[TOGGLE_BIT])
                    begin
                        // Toggling stopped: operation over, recheck done
                        busy <= 1'b0;
                        done <= 1'b1;
                        fail <= (op == OP_PROGRAM)
                              && (first_read[POLL_BIT] != target_data[POLL_BIT]);
                        state <= ST_IDLE;
                    end
                    else if (poll_phase == 2'd3)
                    begin
                        // Still toggling after limit recheck: declare failure
                        busy <= 1'b0;
                        done <= 1'b1;
                        fail <= 1'b1;
                        state <= ST_IDLE;
                    end
                    else
                    begin
                        // Still toggling: read again; if the earlier read showed the limit flag, only one more read before giving up
                        poll_phase <= read_value[LIMIT_BIT] ? 2'd3 : 2'd1;
                        state <= ST_POLL;
                    end
                    read_value <= first_read;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Register read data, valid in the cycle after the read strobe
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            reg_rdata_o <= 32'h0000_0000;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                REG_CTRL: reg_rdata_o <= {28'h0000000, op};
                REG_ADDR: reg_rdata_o <= {13'h0000, target_addr};
                REG_DATA: reg_rdata_o <= {24'h000000, target_data};
                REG_STATUS: reg_rdata_o <= {28'h0000000, reject, fail, done, busy};
                REG_RDATA: reg_rdata_o <= {24'h000000, read_value};
                default: reg_rdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ===== inc/flash_host_pkg.sv
// Constants, commands and register map of the flash command host
package flash_host_pkg;
    // Flash pin widths
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    // Unlock addresses and data, and command codes
    localparam logic [18:0] UNLOCK_ADDR_A = 19'h02AAA;
    localparam logic [18:0] UNLOCK_ADDR_B = 19'h05555;
    localparam logic [7:0] UNLOCK_DATA_A = 8'hAA;
    localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    // Identification read addresses
    localparam logic [18:0] ID_MAKER_ADDR = 19'h00000;
    localparam logic [18:0] ID_PART_ADDR = 19'h00001;
    localparam logic [1:0] PROT_LOW_BITS = 2'h2;
    localparam int SECTOR_LSB = 16;
    // Status bit positions on the data bus
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int LIMIT_BIT = 5;
    localparam int WINDOW_BIT = 3;
    localparam int SECTOR_TOGGLE_BIT = 2;
    // Software register offsets (word index on the command port)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_DATA = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_RDATA = 4'h4;
    // Operation codes written to REG_CTRL bits [3:0]
    localparam logic [3:0] OP_READ = 4'h0;
    localparam logic [3:0] OP_PROGRAM = 4'h1;
    localparam logic [3:0] OP_CHIP_ERASE = 4'h2;
    localparam logic [3:0] OP_SECTOR_ERASE = 4'h3;
    localparam logic [3:0] OP_SUSPEND = 4'h4;
    localparam logic [3:0] OP_RESUME = 4'h5;
    localparam logic [3:0] OP_IDENT = 4'h6;
    localparam logic [3:0] OP_EXTRA_SECTOR = 4'h7;
    localparam logic [3:0] OP_RAW_WRITE = 4'h8;
    // Status register field positions
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_REJECT = 3;
    // Flash strobe timing, in ns, and derived cycle counts at 5 ns
    localparam int CLK_PERIOD_NS = 5;
    localparam int WRITE_PULSE_NS = 35;
    localparam int WRITE_HIGH_NS = 20;
    localparam int READ_ACCESS_NS = 70;
    localparam int READ_RECOVER_NS = 20;
    localparam logic [4:0] WRITE_PULSE_CYC = 5'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] WRITE_HIGH_CYC = 5'((WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Access adds two cycles for the input synchroniser
    localparam logic [4:0] READ_ACCESS_CYC = 5'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2);
    localparam logic [4:0] READ_RECOVER_CYC = 5'((READ_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// ===== hdl/flash_bus_cycle.sv
`timescale 1ns/1ps
// One timed flash bus cycle: a write strobe pulse or a gated read
module flash_bus_cycle
    import flash_host_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Request from the sequencer
    input wire logic start_i,
    input wire logic write_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o,
    // Flash pins
    output logic [ADDR_W-1:0] fl_addr_o,
    output logic [DATA_W-1:0] fl_dq_o,
    output logic fl_dq_oe_o,
    input wire logic [DATA_W-1:0] fl_dq_i,
    output logic fl_ce_n_o,
    output logic fl_oe_n_o,
    output logic fl_we_n_o
);
    typedef enum logic [1:0] {CY_IDLE = 2'b00, CY_ACTIVE = 2'b01, CY_RECOVER = 2'b11} cy_state_t;
    cy_state_t state;
    logic [4:0] count;
    logic is_write;
    logic [DATA_W-1:0] dq_meta;
    logic [DATA_W-1:0] dq_sync;

    // Two-stage synchroniser on the returning data bus
    always_ff @(posedge clk_i)
    begin
        dq_meta <= fl_dq_i;
        dq_sync <= dq_meta;
    end

    // Cycle sequencing: address and strobe change on the same clock edge, data held past the strobe's rise
    always_ff @(posedge clk_i)
    begin
        done_o <= 1'b0;
        if (!resetn_i)
        begin
            state <= CY_IDLE;
            count <= 5'h00;
            is_write <= 1'b0;
            fl_addr_o <= '0;
            fl_dq_o <= '0;
            fl_dq_oe_o <= 1'b0;
            fl_ce_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            fl_we_n_o <= 1'b1;
            rdata_o <= '0;
        end
        else
        begin
            case (state)
                CY_IDLE:
                begin
                    if (start_i)
                    begin
                        is_write <= write_i;
                        fl_addr_o <= addr_i;
                        fl_dq_o <= wdata_i;
                        fl_dq_oe_o <= write_i;
                        fl_ce_n_o <= 1'b0;
                        fl_we_n_o <= !write_i;
                        fl_oe_n_o <= write_i;
                        count <= write_i ? WRITE_PULSE_CYC : READ_ACCESS_CYC;
                        state <= CY_ACTIVE;
                    end
                end
                CY_ACTIVE:
                begin
                    if (count == 5'h01)
                    begin
                        // Data stays driven one more cycle after the rising strobe
                        fl_we_n_o <= 1'b1;
                        fl_oe_n_o <= 1'b1;
                        fl_ce_n_o <= 1'b1;
                        if (!is_write)
                            rdata_o <= dq_sync;
                        count <= is_write ? WRITE_HIGH_CYC : READ_RECOVER_CYC;
                        state <= CY_RECOVER;
                    end
                    else
                        count <= count - 5'h01;
                end
                CY_RECOVER:
                begin
                    fl_dq_oe_o <= 1'b0;
                    if (count == 5'h01)
                    begin
                        done_o <= 1'b1;
                        state <= CY_IDLE;
                    end
                    else
                        count <= count - 5'h01;
                end
                default:
                    state <= CY_IDLE;
            endcase
        end
    end
endmodule

// ===== verification/flash_cmd_host_checker.sv
`timescale 1ns/1ps
// Pin-level timing checks on the flash command host, and a hold check on register read data
module flash_cmd_host_checker
    import flash_host_pkg::*;
(
    // Clock, reset and watched ports
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [ADDR_W-1:0] fl_addr_o,
    input wire logic [DATA_W-1:0] fl_dq_o,
    input wire logic fl_dq_oe_o,
    input wire logic fl_ce_n_o,
    input wire logic fl_oe_n_o,
    input wire logic fl_we_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    write_gate_a: assert property (!fl_we_n_o |-> fl_oe_n_o && !fl_ce_n_o)
        else $error("write strobe without select");
    no_contend_a: assert property (fl_dq_oe_o |-> fl_oe_n_o)
        else $error("data driven while gated");
    pulse_width_a: assert property ($fell(fl_we_n_o) |-> !fl_we_n_o [*6])
        else $error("write pulse short");
    addr_stable_a: assert property (!fl_we_n_o && !$past(fl_we_n_o)
        |-> $stable(fl_addr_o) && $stable(fl_dq_o)) else $error("address moved in pulse");
    data_hold_a: assert property ($rose(fl_we_n_o) |-> fl_dq_oe_o)
        else $error("data released early");
    write_gap_a: assert property ($rose(fl_we_n_o) |-> fl_we_n_o [*3])
        else $error("write high time short");
    read_access_a: assert property ($fell(fl_oe_n_o) |-> (!fl_oe_n_o && !fl_ce_n_o) [*8])
        else $error("read gate short");
    rdata_hold_a: assert property ($past(resetn_i) && !$past(reg_rd_i)
        |-> $stable(reg_rdata_o)) else $error("read data moved");
endmodule

// ===== verification/flash_dev_model.sv
`timescale 1ns/1ps
// Behavioural flash device for the command host bench
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'hC3, // Arbitrary value
    parameter logic [2:0] PROT_SECTOR = 3'h3
)
(
    // Flash pins; no ready pin, status only on data
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    // Forces a pulse-limit failure
    input wire logic fail_i
);
    logic [7:0] mem [0:524287];
    logic [7:0] q = 8'h00;
    logic [7:0] pv;
    logic [18:0] la;
    logic [2:0] es;
    int st = 0;
    int nx;
    int n;
    bit busy, ers, susp, ident, lim, tog, stog, ph;
    // Released bus shows the inverse of the last byte
    assign rdata_o = (ce_n_i | oe_n_i) ? ~q : q;
    initial foreach (mem[i]) mem[i] = 8'hFF;
    // Address taken on strobe fall
    always @(negedge we_n_i) la = addr_i;
    // Dropping the failure clears busy only, ending the running operation
    always @(negedge fail_i) busy = 0;
    task automatic go(input bit e);
        busy = 1;
        ers = e;
        n = e ? 6 : 4;
        lim = 0;
        nx = 0;
    endtask
    // Command decoder, data taken on strobe rise
    always @(posedge we_n_i)
    begin
        if (busy)
        begin
            if (ers && wdata_i == CMD_SUSPEND) susp = 1;
            if (ers && wdata_i == CMD_RESUME) susp = 0;
        end
        else
        begin
            // Only the low eleven bits take part in matching
            nx = (wdata_i == UNLOCK_DATA_A && la[10:0] == UNLOCK_ADDR_A[10:0]) ? 1 : 0;
            if (st == 1 && wdata_i == UNLOCK_DATA_B && la[10:0] == UNLOCK_ADDR_B[10:0]) nx = 2;
            if (st == 3)
            begin
                mem[la] = mem[la] & wdata_i;
                pv = wdata_i;
                go(0);
            end
            if (st == 2 && !ph && la[10:0] == UNLOCK_ADDR_A[10:0])
            begin
                ident = wdata_i == CMD_IDENT;
                ph = wdata_i == CMD_ERASE_SETUP;
                if (wdata_i == CMD_PROGRAM) nx = 3;
            end
            else if (st == 2 && ph)
            begin
                ph = 0;
                es = la[18:16];
                if (wdata_i == CMD_CHIP_ERASE && la[10:0] == UNLOCK_ADDR_A[10:0])
                begin
                    foreach (mem[i]) mem[i] = 8'hFF;
                    go(1);
                end
                if (wdata_i == CMD_SECTOR_ERASE)
                begin
                    for (int i = 0; i < 65536; i++) mem[{es, i[15:0]}] = 8'hFF;
                    go(1);
                end
            end
            st = nx;
        end
    end
    // Reads: status while an operation runs, else identity or array
    always @(negedge oe_n_i)
    begin
        if (busy && !susp && !lim)
        begin
            tog = ~tog;
            if (addr_i[18:16] == es) stog = ~stog;
            if (fail_i && n < 3) lim = 1;
            else n--;
            busy = n > 0;
        end
        if (busy && !(susp && addr_i[18:16] != es))
            q = ers ? {susp, tog, lim, 2'h1, stog, 2'h0} : {~pv[7], tog, lim, 5'h0};
        else if (ident)
            q = addr_i[1:0] == 2'h0 ? MAKER_CODE : addr_i[1:0] == 2'h1 ? PART_CODE
                : {7'h0, addr_i[18:16] == PROT_SECTOR};
        else
            q = mem[addr_i];
    end
endmodule

// ===== verification/flash_cmd_host_tb.sv
`timescale 1ns/1ps
// Self-checking bench: command host driving the flash device model
module flash_cmd_host_tb;
    import flash_host_pkg::*;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
    logic clk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'h0;
    logic reg_rd_i = 1'h0;
    logic fail = 1'h0;
    logic [31:0] reg_rdata_o;
    logic [ADDR_W-1:0] fl_addr_o;
    logic [DATA_W-1:0] fl_dq_o, fl_dq_i, dev_q;
    logic fl_dq_oe_o, fl_ce_n_o, fl_oe_n_o, fl_we_n_o;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 32'h179dcbff;
    int ref_m [int];
    // Shared data wire seen by both ends
    assign fl_dq_i = fl_dq_oe_o ? fl_dq_o : dev_q;
    flash_cmd_host u_flash_cmd_host (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_dq_i, .fl_ce_n_o,
        .fl_oe_n_o, .fl_we_n_o);
    flash_dev_model u_flash_dev_model (.addr_i(fl_addr_o), .wdata_i(fl_dq_i), .rdata_o(dev_q),
        .ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o), .fail_i(fail));
    initial forever #2.5 clk_i = ~clk_i;
    task automatic print_verdict;
        if (n_mismatch == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge clk_i);
        reg_wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        @(posedge clk_i);
        reg_rd_i <= 1'h0;
        #1 d = reg_rdata_o;
    endtask
    // Starts one operation and polls status until busy clears
    task automatic op(input logic [3:0] c, input logic [18:0] a, input logic [7:0] d,
        output logic [31:0] s);
        int i;
        wr(REG_ADDR, {13'h0, a});
        wr(REG_DATA, {24'h0, d});
        wr(REG_CTRL, {28'h0, c});
        repeat (2) @(posedge clk_i);
        i = 0;
        s = 32'h1;
        while (s[ST_BUSY] !== 1'h0 && i < 3000)
        begin
            rd(REG_STATUS, s);
            i++;
        end
        if (i >= 3000) n_mismatch++;
    endtask
    task automatic chk_rd(input logic [18:0] a, input logic [7:0] e);
        logic [31:0] s;
        op(OP_READ, a, 8'h00, s);
        rd(REG_RDATA, s);
        `CHK(s[7:0], e)
    endtask
    // Watchdog
    initial
    begin
        #400000;
        n_mismatch++;
        print_verdict();
    end
    initial
    begin
        logic [31:0] s, a, d;
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'h1;
        rd(REG_STATUS, s);
        `CHK(s[3:0], 4'h0)
        wr(REG_ADDR, 32'h12345);
        wr(4'hF, 32'h0);
        rd(REG_ADDR, s);
        `CHK(s[18:0], 19'h12345)
        op(OP_RAW_WRITE, UNLOCK_ADDR_A, UNLOCK_DATA_A, s);
        for (int k = 0; k < 5; k++)
        begin
            a = $random(seed) & 32'h7FFFF;
            d = $random(seed) & 32'hFF;
            op(OP_PROGRAM, a[18:0], d[7:0], s);
            `CHK(s[3:0], 4'h2)
            ref_m[a] = (ref_m.exists(a) ? ref_m[a] : 255) & d;
            chk_rd(a[18:0], 8'(ref_m[a]));
        end
        op(OP_SECTOR_ERASE, a[18:0], 8'h00, s);
        `CHK(s[3:0], 4'h2)
        foreach (ref_m[i]) if (i[18:16] == a[18:16]) ref_m[i] = 255;
        op(OP_EXTRA_SECTOR, a[18:0], 8'h00, s);
        `CHK(s[ST_REJECT], 1'h1)
        op(OP_SUSPEND, a[18:0], 8'h00, s);
        op(OP_RESUME, a[18:0], 8'h00, s);
        `CHK(s[ST_FAIL], 1'h0)
        foreach (ref_m[i]) chk_rd(i[18:0], 8'(ref_m[i]));
        op(OP_CHIP_ERASE, 19'h00000, 8'h00, s);
        `CHK(s[3:0], 4'h2)
        foreach (ref_m[i]) chk_rd(i[18:0], 8'hFF);
        op(OP_IDENT, 19'h00000, 8'h00, s);
        chk_rd(ID_MAKER_ADDR, 8'h5A);
        chk_rd(ID_PART_ADDR, 8'hC3);
        chk_rd({3'h3, 14'h0, PROT_LOW_BITS}, 8'h01);
        chk_rd({3'h1, 14'h0, PROT_LOW_BITS}, 8'h00);
        fail <= 1'h1;
        op(OP_PROGRAM, 19'h00200, 8'h0F, s);
        `CHK(s[ST_FAIL], 1'h1)
        fail <= 1'h0;
        print_verdict();
    end
endmodule
bind flash_cmd_host flash_cmd_host_checker u_flash_cmd_host_checker (.clk_i, .resetn_i,
    .reg_rd_i, .reg_rdata_o, .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_ce_n_o, .fl_oe_n_o,
    .fl_we_n_o);
